// ---- rtl/psc_power_ctrl.sv ----
// What this block does
// - Always-on domain stays powered in every mode.
// - System domain off from gating entry until power-up ends.
// - Peripheral domain can be switched off when idle.
// - Four RAM cell domains, 32, 16, 16, 32 kB.
// - Debug domain powers only core debug logic.
// - Radio domain holds radio phy and link core.
// - Sleep: no gating; peripheral and radio follow enables.
// - Extended sleep: only always-on and retained RAM stay on.
// - Wake from extended sleep mirrors unless code is retained or reset on wake is set.
// - Deep sleep: all but always-on off, reset after wake.
// - Deep sleep wakes only on external interrupt or POR source.
// - Entry auto-offs system, debug, peripheral and radio domains.
// - Extended or deep sleep turns analog blocks off.
// - Always-on registers keep values through sleep.
// - OTP and debug freeze registers retained through sleep.
// - Link core second config register retained through sleep.
// - Power-up sequence runs on every wake from extended or deep sleep.
// - Hardware mirrors OTP with retained word count.
`timescale 1ns/1ps
`default_nettype none
module psc_power_ctrl #(
  parameter int unsigned PUP_TIMEOUT = psc_pkg::PUP_TIMEOUT_CYC
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [psc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Processor sleep handshake
  input wire logic cpu_wfi,
  input wire logic deep_sleep_request,
  output logic cpu_hold,
  output logic hw_reset,
  // Wake sources
  input wire logic wake_irq,
  input wire logic ext_irq,
  input wire logic por_src,
  // Analog status
  input wire logic ldo_ready,
  input wire logic xtal_ready,
  // OTP mirroring engine
  input wire logic mirror_done,
  output logic mirror_req,
  output logic [31:0] mirror_words,
  // Domain switches
  output logic always_on_domain,
  output logic system_domain,
  output logic peripheral_domain,
  output logic debug_domain,
  output logic radio_domain,
  output logic [psc_pkg::RAM_CELLS-1:0] ram_cell_domain,
  output logic analog_on,
  // Retained configuration and reported power mode
  output logic debug_freeze_enable,
  output logic [31:0] link_core_config_two,
  output logic [1:0] power_mode
);
  import psc_pkg::*;

  // One clock: every check shares its edge and reset
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  psc_state_e state_ff, nxt_state;
  logic [CTRL_W-1:0] ctrl_ff;
  logic [31:0] ret_ff [RET_REGS];
  logic deep_ff;
  logic pup_start_ff;
  logic pup_done;
  logic pup_timeout;
  logic [8:0] nxt_dom;

  // Field views of the power control word
  wire rst_on_wake = ctrl_ff[CTRL_RST_WAKE];
  wire per_off = ctrl_ff[CTRL_PER_OFF];
  wire rad_off = ctrl_ff[CTRL_RAD_OFF];
  wire code_in_ram = ctrl_ff[CTRL_CODE_RAM];
  wire [3:0] ram_on = ctrl_ff[CTRL_RAM_ON_LSB +: 4];
  wire [3:0] ram_retain = ctrl_ff[CTRL_RET_LSB +: 4];

  // Bus decode
  wire acc = psel && penable && pready;
  wire wr = acc && pwrite;
  wire hit_ctrl = (paddr == OFF_CTRL);
  wire hit_stat = (paddr == OFF_STAT);
  wire hit_ret = (paddr >= OFF_RET_FIRST) && (paddr <= OFF_RET_LAST)
    && (paddr[1:0] == 2'h0);
  wire [2:0] ret_idx = ret_index(paddr);
  wire mapped = hit_ctrl || hit_stat || hit_ret;

  // Retained word index from byte address
  function automatic logic [2:0] ret_index(input logic [11:0] a);
    logic [11:0] d;
    d = a - OFF_RET_FIRST;
    return d[4:2];
  endfunction

  // Domain map per state: {analog, ram[3:0], rad, dbg, per, sys}
  // Fields come in as arguments so the assign sees every change
  function automatic logic [8:0] dom_map(input psc_state_e st,
    input logic [3:0] on, input logic [3:0] keep, input logic p_off,
    input logic r_off);
    logic [8:0] m;
    m = '0;
    case (st)
      // sleep keeps system on, per/rad follow enables
      ST_SLEEP: m = {1'b1, on, !r_off, 1'b1, !p_off, 1'b1};
      ST_GATE, ST_OFF: m = {1'b0, on & keep, 4'h0};
      // analog up first, domains still off
      ST_PWRUP: m = {1'b1, on & keep, 4'h0};
      // domains restored no later than the cycle the core is let go
      ST_MIRROR, ST_RELEASE: m = {1'b1, on, 4'hF};
      default: m = {1'b1, on, 4'hF};
    endcase
    return m;
  endfunction

  // Wake source accepted in the off state
  // deep sleep ignores ordinary wake interrupts
  wire wake_ok = deep_ff ? (ext_irq || por_src)
    : (wake_irq || ext_irq || por_src);
  // mirror only when code is not kept in RAM
  wire need_mirror = !deep_ff && !code_in_ram && !rst_on_wake;
  // deep sleep always ends in a reset
  wire need_reset = deep_ff || rst_on_wake;

  // Next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_ACTIVE: begin
        // gate only on wait-for-interrupt with request
        if (cpu_wfi && deep_sleep_request) begin
          nxt_state = ST_GATE;
        end else if (cpu_wfi) begin
          nxt_state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wake_irq || ext_irq || por_src) begin
          nxt_state = ST_ACTIVE;
        end
      end
      ST_GATE: nxt_state = ST_OFF;
      ST_OFF: begin
        if (wake_ok) begin
          nxt_state = ST_PWRUP;
        end
      end
      ST_PWRUP: begin
        if (pup_done && need_mirror) begin
          nxt_state = ST_MIRROR;
        end else if (pup_done) begin
          nxt_state = ST_RELEASE;
        end
      end
      ST_MIRROR: begin
        if (mirror_done) begin
          nxt_state = ST_RELEASE;
        end
      end
      ST_RELEASE: nxt_state = ST_ACTIVE;
      default: nxt_state = ST_ACTIVE;
    endcase
  end

  assign nxt_dom = dom_map(nxt_state, ram_on, ram_retain, per_off, rad_off);

  // State and sleep kind; a mode is fixed at entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_ACTIVE;
      deep_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      // no retained cell means deep sleep
      if (state_ff == ST_ACTIVE && nxt_state == ST_GATE) begin
        deep_ff <= (ram_retain == 4'h0);
      end
    end
  end

  // Registered domain switches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      always_on_domain <= 1'b1;
      system_domain <= 1'b1;
      peripheral_domain <= 1'b1;
      debug_domain <= 1'b1;
      radio_domain <= 1'b1;
      ram_cell_domain <= CTRL_RESET[CTRL_RAM_ON_LSB +: 4];
      analog_on <= 1'b1;
    end else begin
      always_on_domain <= 1'b1;
      system_domain <= nxt_dom[0];
      peripheral_domain <= nxt_dom[1];
      // debug auto off with the core
      debug_domain <= nxt_dom[2];
      // radio phy and link core together
      radio_domain <= nxt_dom[3];
      ram_cell_domain <= nxt_dom[7:4];
      // analog off in extended and deep sleep
      analog_on <= nxt_dom[8];
    end
  end

  // Core hold, reset, mirror request and mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_hold <= 1'b0;
      hw_reset <= 1'b0;
      mirror_req <= 1'b0;
      pup_start_ff <= 1'b0;
      power_mode <= MODE_ACTIVE;
    end else begin
      cpu_hold <= (nxt_state == ST_GATE) || (nxt_state == ST_OFF)
        || (nxt_state == ST_PWRUP) || (nxt_state == ST_MIRROR);
      // reset pulse one cycle after the core is released
      hw_reset <= (state_ff == ST_RELEASE) && need_reset;
      // mirror request held until the engine ends
      mirror_req <= (nxt_state == ST_MIRROR);
      // every wake from extended or deep sleep starts the power-up sequence
      pup_start_ff <= (state_ff == ST_OFF) && wake_ok;
      if (nxt_state == ST_ACTIVE) begin
        power_mode <= MODE_ACTIVE;
      end else if (nxt_state == ST_SLEEP) begin
        power_mode <= MODE_SLEEP;
      end else if (state_ff == ST_ACTIVE) begin
        power_mode <= (ram_retain == 4'h0) ? MODE_DEEP : MODE_EXT;
      end
    end
  end

  psc_pwrup_seq #(
    .TIMEOUT_CYC(PUP_TIMEOUT)
  ) u_pwrup (
    .pclk(pclk),
    .presetn(presetn),
    .start(pup_start_ff),
    .ldo_ready(ldo_ready),
    .xtal_ready(xtal_ready),
    .done(pup_done),
    .timed_out(pup_timeout)
  );

  // Control word; reset only by presetn, never by sleep
  // bits written by software steer the gating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= CTRL_RESET;
    end else if (wr && hit_ctrl) begin
      ctrl_ff <= pwdata[CTRL_W-1:0];
    end
  end

  // retained words live in always-on flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < RET_REGS; i++) begin
        ret_ff[i] <= RET_RESET;
      end
    end else if (wr && hit_ret) begin
      ret_ff[ret_idx] <= (ret_idx == RET_DBG_FREEZE)
        ? (pwdata & DBG_FREEZE_MASK) : pwdata;
    end
  end

  assign mirror_words = ret_ff[RET_OTP_WORDS];
  assign debug_freeze_enable = ret_ff[RET_DBG_FREEZE][0];
  assign link_core_config_two = ret_ff[RET_LINK_CFG2];

  // Status word: state, mode, timeout flag
  wire [31:0] stat_word = {24'h000000, pup_timeout, power_mode,
    deep_ff, 1'b0, state_ff};
  wire [31:0] rd_mux = hit_ctrl ? {20'h00000, ctrl_ff}
    : hit_stat ? stat_word
    : hit_ret ? ret_ff[ret_idx] : 32'h0000_0000;

  // Zero-wait APB: ready in every access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (psel && !penable && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  // Checks, on the default clock and reset above
  chk_aon_always: assert property (
    always_on_domain)
    else $error("always-on domain switched off");
  chk_sys_off_gate: assert property (
    (state_ff == ST_OFF) |-> !system_domain && !debug_domain)
    else $error("system or debug domain on while gated");
  chk_sleep_nogate: assert property (
    (state_ff == ST_SLEEP) |-> system_domain
      && (peripheral_domain == !per_off) && (radio_domain == !rad_off))
    else $error("sleep mode gated a domain");
  chk_ext_retain: assert property (
    (state_ff == ST_OFF) |-> ram_cell_domain == (ram_on & ram_retain)
      && !radio_domain && !peripheral_domain)
    else $error("extended sleep left a domain on");
  chk_deep_wake: assert property (
    (state_ff == ST_OFF && deep_ff && !ext_irq && !por_src)
      |=> state_ff == ST_OFF)
    else $error("deep sleep woke on wrong source");
  chk_analog_off: assert property (
    $rose(state_ff == ST_GATE) |-> !analog_on ##1 !analog_on)
    else $error("analog left on at sleep entry");
  chk_gate_wfi: assert property (
    (state_ff == ST_GATE) |-> $past(cpu_wfi) && $past(deep_sleep_request))
    else $error("gating without wait-for-interrupt");
  chk_restore_first: assert property (
    $fell(cpu_hold) |-> system_domain && debug_domain && analog_on)
    else $error("core released before domains restored");
  chk_mirror_skip: assert property (
    (state_ff == ST_PWRUP && pup_done && code_in_ram)
      |=> state_ff == ST_RELEASE ##1 !mirror_req)
    else $error("mirroring with code retained");
  chk_deep_reset: assert property (
    (state_ff == ST_RELEASE && deep_ff) |=> hw_reset)
    else $error("no reset after deep sleep wake");
  chk_pup_start: assert property (
    (state_ff == ST_OFF && wake_ok) |=> state_ff == ST_PWRUP
      && analog_on)
    else $error("wake without power-up sequence");
  chk_freeze_bit: assert property (
    ret_ff[RET_DBG_FREEZE][31:1] == 31'h0000_0000)
    else $error("debug freeze word holds extra bits");

  cov_sleep: cover property (
    state_ff == ST_SLEEP ##1 state_ff == ST_ACTIVE);
  cov_ext_mirror: cover property (
    state_ff == ST_MIRROR ##1 state_ff == ST_RELEASE);
  cov_deep_reset: cover property (
    hw_reset && deep_ff);
  cov_timeout: cover property (
    $rose(pup_timeout));
endmodule // psc_power_ctrl
`default_nettype wire

// ---- rtl/psc_pkg.sv ----
`default_nettype none
package psc_pkg;
  // Clock and power-up timing
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned PUP_TIMEOUT_NS = 1500000;
  // Longest wait, so rounded down
  localparam int unsigned PUP_TIMEOUT_CYC = PUP_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int unsigned PUP_CNT_W = 17;

  // RAM cell sizes in cell order
  localparam int unsigned RAM_CELLS = 4;
  localparam int unsigned RAM1_KB = 32;
  localparam int unsigned RAM2_KB = 16;
  localparam int unsigned RAM3_KB = 16;
  localparam int unsigned RAM4_KB = 32;

  // APB register map
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STAT = 12'h004;
  localparam logic [11:0] OFF_RET_FIRST = 12'h008;
  localparam logic [11:0] OFF_RET_LAST = 12'h024;
  localparam int unsigned RET_REGS = 8;
  // Retained word indexes
  localparam logic [2:0] RET_OTP_TARGET = 3'h0;
  localparam logic [2:0] RET_OTP_CELL = 3'h1;
  localparam logic [2:0] RET_OTP_MODE = 3'h2;
  localparam logic [2:0] RET_OTP_WORDS = 3'h3;
  localparam logic [2:0] RET_OTP_TIM1 = 3'h4;
  localparam logic [2:0] RET_OTP_TIM2 = 3'h5;
  localparam logic [2:0] RET_DBG_FREEZE = 3'h6;
  localparam logic [2:0] RET_LINK_CFG2 = 3'h7;
  localparam logic [31:0] RET_RESET = 32'h0000_0000;
  localparam logic [31:0] DBG_FREEZE_MASK = 32'h0000_0001;

  // Power control word fields
  localparam int unsigned CTRL_W = 12;
  localparam int unsigned CTRL_RST_WAKE = 0;
  localparam int unsigned CTRL_PER_OFF = 1;
  localparam int unsigned CTRL_RAD_OFF = 2;
  localparam int unsigned CTRL_CODE_RAM = 3;
  localparam int unsigned CTRL_RAM_ON_LSB = 4;
  localparam int unsigned CTRL_RET_LSB = 8;
  localparam logic [11:0] CTRL_RESET = 12'hFF0;

  // Power-mode controller states
  typedef enum logic [2:0] {
    ST_ACTIVE = 3'h0,
    ST_SLEEP = 3'h1,
    ST_GATE = 3'h2,
    ST_OFF = 3'h3,
    ST_PWRUP = 3'h4,
    ST_MIRROR = 3'h5,
    ST_RELEASE = 3'h6
  } psc_state_e;

  // Reported power mode
  typedef enum logic [1:0] {
    MODE_ACTIVE = 2'h0,
    MODE_SLEEP = 2'h1,
    MODE_EXT = 2'h2,
    MODE_DEEP = 2'h3
  } psc_mode_e;
endpackage
`default_nettype wire

// ---- rtl/psc_pwrup_seq.sv ----
`timescale 1ns/1ps
`default_nettype none
module psc_pwrup_seq #(
  parameter int unsigned TIMEOUT_CYC = psc_pkg::PUP_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Sequence control
  input wire logic start,
  input wire logic ldo_ready,
  input wire logic xtal_ready,
  output logic done,
  output logic timed_out
);
  import psc_pkg::*;

  logic busy_ff;
  logic [PUP_CNT_W-1:0] cnt_ff;
  wire settled = ldo_ready && xtal_ready;
  // Stuck analog status must not hang the wake-up
  wire expired = (cnt_ff == PUP_CNT_W'(TIMEOUT_CYC - 1));
  wire finish = busy_ff && (settled || expired);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_ff <= 1'b0;
      cnt_ff <= '0;
      done <= 1'b0;
      timed_out <= 1'b0;
    end else begin
      done <= finish;
      if (start) begin
        busy_ff <= 1'b1;
        cnt_ff <= '0;
        timed_out <= 1'b0;
      end else if (finish) begin
        busy_ff <= 1'b0;
        timed_out <= !settled;
      end else if (busy_ff) begin
        cnt_ff <= cnt_ff + 1'b1;
      end
    end
  end

  // chk_pup_bounded guards the timeout count
  chk_pup_bounded: assert property (
    @(posedge pclk) disable iff (!presetn)
    busy_ff |-> cnt_ff < PUP_CNT_W'(TIMEOUT_CYC))
    else $error("power-up wait exceeded its timeout");
endmodule // psc_pwrup_seq
`default_nettype wire

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import psc_pkg::*;
  // Short power-up timeout keeps wake runs brief
  localparam int unsigned PUP = 20;
  // Active: all domains on, RAM 4'hF, analog on, not held
  localparam logic [12:0] ACT = 13'h1FF8;
  // Bus, sleep handshake, wake, analog status and mirror inputs
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic cpu_wfi = 1'b0;
  logic deep_sleep_request = 1'b0;
  logic wake_irq = 1'b0;
  logic ext_irq = 1'b0;
  logic por_src = 1'b0;
  logic ldo_ready = 1'b1;
  logic xtal_ready = 1'b1;
  logic mirror_done = 1'b0;
  // Design outputs
  logic [31:0] prdata;
  logic pready, pslverr, cpu_hold, hw_reset, mirror_req;
  logic [31:0] mirror_words, link_core_config_two;
  logic always_on_domain, system_domain, peripheral_domain;
  logic debug_domain, radio_domain, analog_on, debug_freeze_enable;
  logic [3:0] ram_cell_domain;
  logic [1:0] power_mode;
  // Bench bookkeeping
  int failures = 0;
  int n_checks = 0;
  int n_hwrst = 0;
  int n_mirr = 0;
  logic [64:0] q_apb[$];
  logic [155:0] q_snap[$];
  logic probe = 1'b0;
  logic [31:0] w [8];

  always #12.5 pclk = ~pclk;

  psc_power_ctrl #(.PUP_TIMEOUT(PUP)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpu_wfi(cpu_wfi),
    .deep_sleep_request(deep_sleep_request), .cpu_hold(cpu_hold),
    .hw_reset(hw_reset), .wake_irq(wake_irq), .ext_irq(ext_irq),
    .por_src(por_src), .ldo_ready(ldo_ready), .xtal_ready(xtal_ready),
    .mirror_done(mirror_done), .mirror_req(mirror_req),
    .mirror_words(mirror_words), .always_on_domain(always_on_domain),
    .system_domain(system_domain), .peripheral_domain(peripheral_domain),
    .debug_domain(debug_domain), .radio_domain(radio_domain),
    .ram_cell_domain(ram_cell_domain), .analog_on(analog_on),
    .debug_freeze_enable(debug_freeze_enable),
    .link_core_config_two(link_core_config_two), .power_mode(power_mode));

  task automatic check_word(input string nm, input logic [31:0] e,
                            input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  task automatic check_snap(input logic [77:0] e, input logic [77:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected domain snapshot: expected %h, seen %h", e, g);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // One APB transfer; note holds mask, data and error flag
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic [31:0] m,
                     input logic err);
    q_apb.push_back({m, d, err});
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the slave
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [12:0] dv(input logic s, p, d, r,
                                     input logic [3:0] m, input logic a, h,
                                     input logic [1:0] md);
    return {1'b1, s, p, d, r, m, a, h, md};
  endfunction

  // Retained values come from the bench copy, never from the design
  task automatic expect_dom(input logic [12:0] d, input logic [12:0] m);
    q_snap.push_back({m, {65{1'b1}}, d, w[6][0], w[7], w[3]});
    @(posedge pclk);
    probe <= 1'b1;
    @(posedge pclk);
    probe <= 1'b0;
  endtask

  task automatic go_sleep(input logic ds);
    @(posedge pclk);
    cpu_wfi <= 1'b1;
    deep_sleep_request <= ds;
    repeat (3) @(posedge pclk);
    cpu_wfi <= 1'b0;
    deep_sleep_request <= 1'b0;
  endtask

  task automatic wake(input logic [2:0] v);
    @(posedge pclk);
    {por_src, ext_irq, wake_irq} <= v;
    repeat (2) @(posedge pclk);
    {por_src, ext_irq, wake_irq} <= 3'b000;
  endtask

  // Bounded wait for mirroring request or for the core back at work
  task automatic wait_for(input logic mirr);
    int i;
    i = 0;
    while (i < 300 && (mirr ? mirror_req !== 1'b1 :
           (cpu_hold !== 1'b0 || power_mode !== MODE_ACTIVE))) begin
      @(posedge pclk);
      i++;
    end
    if (i == 300) begin
      failures++;
      $display("unexpected wait: expected response, seen none");
    end
  endtask

  // Bus result watcher
  always @(posedge pclk) begin
    logic [64:0] n;
    if (psel && penable && pready === 1'b1) begin
      n = q_apb.pop_front();
      if (n[64:33] != 32'h0) begin
        check_word("prdata", n[64:33] & n[32:1], n[64:33] & prdata);
      end
      check_word("pslverr", {31'h0, n[0]}, {31'h0, pslverr});
    end
  end

  // Domain watcher and pulse counters
  always @(posedge pclk) begin
    logic [155:0] n;
    if (probe) begin
      n = q_snap.pop_front();
      check_snap(n[155:78] & n[77:0], n[155:78] & {always_on_domain,
        system_domain, peripheral_domain, debug_domain, radio_domain,
        ram_cell_domain, analog_on, cpu_hold, power_mode,
        debug_freeze_enable, link_core_config_two, mirror_words});
    end
    if (hw_reset === 1'b1) n_hwrst++;
    if ($rose(mirror_req)) n_mirr++;
  end

  // Watchdog well beyond the expected few hundred cycles
  initial begin
    #500000;
    failures++;
    finish_test();
  end

  initial begin
    int s;
    void'($urandom(34684));
    for (s = 0; s < 8; s++) w[s] = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    expect_dom(ACT, 13'h1FFF);
    apb(1'b0, OFF_CTRL, {20'h0, CTRL_RESET}, 32'hFFFF_FFFF, 1'b0);
    apb(1'b0, OFF_STAT, 32'h0, 32'h0000_00FF, 1'b0);
    apb(1'b1, 12'h028, 32'hA5A5_5A5A, 32'h0, 1'b1);
    apb(1'b0, 12'h028, 32'h0, 32'hFFFF_FFFF, 1'b1);
    $display("test reset done");
    // Random retained words; freeze word keeps bit 0 only
    for (s = 0; s < 8; s++) begin
      w[s] = $urandom();
      apb(1'b1, OFF_RET_FIRST + 12'(4 * s), w[s], 32'h0, 1'b0);
    end
    w[6] = w[6] & DBG_FREEZE_MASK;
    for (s = 0; s < 8; s++) begin
      apb(1'b0, OFF_RET_FIRST + 12'(4 * s), w[s], '1, 1'b0);
    end
    $display("test retention registers done");
    // Sleep: peripheral follows its enable, nothing gated
    apb(1'b1, OFF_CTRL, 32'h0000_0FF2, 32'h0, 1'b0);
    go_sleep(1'b0);
    expect_dom(dv(1, 0, 1, 1, 4'hF, 1, 0, MODE_SLEEP), 13'h1F07);
    wake(3'b001);
    wait_for(1'b0);
    expect_dom(ACT, 13'h1FFF);
    $display("test sleep done");
    // Unneeded fourth RAM cell switched off while active
    apb(1'b1, OFF_CTRL, 32'h0000_0F72, 32'h0, 1'b0);
    expect_dom(ACT & 13'h1F7F, 13'h1FFF);
    $display("test ram cell switch done");
    // Extended sleep keeping cell 4, then OTP mirroring
    apb(1'b1, OFF_CTRL, 32'h0000_08F6, 32'h0, 1'b0);
    go_sleep(1'b1);
    expect_dom(dv(0, 0, 0, 0, 4'h8, 0, 1, MODE_EXT), '1);
    wake(3'b001);
    wait_for(1'b1);
    expect_dom(ACT | 13'h0004, 13'h1FFC);
    @(posedge pclk);
    mirror_done <= 1'b1;
    @(posedge pclk);
    mirror_done <= 1'b0;
    wait_for(1'b0);
    expect_dom(ACT, 13'h1FFF);
    apb(1'b0, OFF_CTRL, 32'h0000_08F6, '1, 1'b0);
    check_word("mirror runs", 32'd1, 32'(n_mirr));
    $display("test extended sleep done");
    // Code kept in RAM: no mirroring; slow LDO forces the timeout
    apb(1'b1, OFF_CTRL, 32'h0000_0FFE, 32'h0, 1'b0);
    go_sleep(1'b1);
    expect_dom(dv(0, 0, 0, 0, 4'hF, 0, 1, MODE_EXT), '1);
    ldo_ready <= 1'b0;
    wake(3'b001);
    wait_for(1'b0);
    ldo_ready <= 1'b1;
    expect_dom(ACT, 13'h1FFF);
    apb(1'b0, OFF_STAT, 32'h0000_0080, 32'h0000_0080, 1'b0);
    check_word("mirror runs", 32'd1, 32'(n_mirr));
    $display("test retained code done");
    // Deep sleep: general wake ignored, external and POR wake
    for (s = 1; s < 3; s++) begin
      apb(1'b1, OFF_CTRL, 32'h0000_00F6, 32'h0, 1'b0);
      go_sleep(1'b1);
      expect_dom(dv(0, 0, 0, 0, 4'h0, 0, 1, MODE_DEEP), '1);
      wake(3'b001);
      repeat (10) @(posedge pclk);
      expect_dom(dv(0, 0, 0, 0, 4'h0, 0, 1, MODE_DEEP), '1);
      wake(3'(1 << s));
      wait_for(1'b0);
      expect_dom(ACT, 13'h1FFF);
    end
    repeat (4) @(posedge pclk);
    check_word("hw reset pulses", 32'd2, 32'(n_hwrst));
    check_word("mirror runs", 32'd1, 32'(n_mirr));
    $display("test deep sleep done");
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
